/* logic/gtpm_pkg.sv */
// Constants shared by the time pulse and time mark block
`default_nettype none

package gtpm_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_UNLK_PER = 8'h04;
    localparam logic [7:0] REG_UNLK_WID = 8'h08;
    localparam logic [7:0] REG_LOCK_PER = 8'h0c;
    localparam logic [7:0] REG_LOCK_WID = 8'h10;
    localparam logic [7:0] REG_CABLE_DLY = 8'h14;
    localparam logic [7:0] REG_USER_DLY = 8'h18;
    localparam logic [7:0] REG_ASSIST_SEC = 8'h1c;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_MARK_INFO = 8'h24;
    localparam logic [7:0] REG_RISE_SEC = 8'h28;
    localparam logic [7:0] REG_RISE_NS = 8'h2c;
    localparam logic [7:0] REG_FALL_SEC = 8'h30;
    localparam logic [7:0] REG_FALL_NS = 8'h34;
    localparam logic [7:0] REG_MARK_ACC = 8'h38;
    localparam logic [7:0] REG_NEXT_SEC = 8'h3c;
    localparam logic [7:0] REG_NEXT_NS = 8'h40;
    localparam logic [7:0] REG_FREQ_MEAS = 8'h44;
    localparam logic [7:0] REG_LOCAL_SEC = 8'h48;

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int CB_PULSE_EN = 0;
    localparam int CB_RATE_FREQ = 1;
    localparam int CB_WID_RATIO = 2;
    localparam int CB_ALIGN = 3;
    localparam int CB_ALT_LOCK = 4;
    localparam int CB_POL = 5;
    localparam int CB_FREQ_LOCK = 6;
    localparam int CB_GRID_LO = 8;
    localparam int CB_MARK_EN = 12;
    localparam int CB_ASSIST_ARM = 16;

    // ------------------------------------------------------------------
    // Reset values and control write mask
    // ------------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0120;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_177f;
    localparam logic [31:0] PER_RST = 32'h000f_4240;
    localparam logic [31:0] WID_RST = 32'h0001_86a0;

    // ------------------------------------------------------------------
    // Time units and encodings
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int FRAC_BITS = 16;
    localparam logic [31:0] STEP_BASE = 32'(CLK_PERIOD_NS) << FRAC_BITS;
    localparam logic [29:0] NS_PER_SEC = 30'h3b9a_ca00;
    localparam logic [63:0] NS_PER_US = 64'h3e8;
    localparam logic [63:0] PCT_FULL = 64'h64;
    localparam logic [2:0] SRC_LOCAL = 3'h5;

endpackage : gtpm_pkg

`default_nettype wire

/* logic/gtpm_time_pulse_mark.sv */
// Time pulse generator and external event time mark unit, APB slave
//
// Contract
// - Stamp input edges against a selectable time base.
// - Mark report at next epoch if enabled and edges seen.
// - Report: mark times, edge flags, source, validity, count, accuracy.
// - Keep only latest rise and fall per epoch.
// - Cable and user delay also correct mark stamps.
// - Pulses only while pulse enable set.
// - Rate type: frequency or period.
// - Width type: microseconds or percent duty.
// - Alternate-on-lock uses locked values once time valid.
// - Else unlocked period and width.
// - Pulse advanced by cable plus user delay.
// - Frequency lock uses recovered satellite frequency.
// - Alignment puts pulses on top of second once time valid.
// - Polarity one: rising first edge; zero: falling.
// - Grid 0 UTC..4 Galileo; also next-pulse time base.
// - 1 s period, 0.1 s width both modes: 1 Hz regardless of lock.
// - Report time of each next pulse.
// - Power-up loads local time from backup clock.
`default_nettype none

module gtpm_time_pulse_mark
    import gtpm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Pins
    input wire logic external_event_input,
    output logic periodic_pulse_output,
    // Navigation solution
    input wire logic epochTick,
    input wire logic timeValid,
    input wire logic gnssFreqValid,
    input wire logic [15:0] freqCorr,
    input wire logic [31:0] timeAccNs,
    output logic [2:0] offsetSel,
    input wire logic [31:0] gridOffsetNs,
    // Backup real-time clock
    input wire logic rtcValid,
    input wire logic [31:0] rtcSec,
    input wire logic [29:0] rtcNs,
    // Report strobes
    output logic markReportStrobe,
    output logic nextPulseStrobe
);
    // ------------------------------
    // Declarations
    // ------------------------------
    logic [31:0] ctrl_q, unlkPer_q, unlkWid_q, lockPer_q, lockWid_q;
    logic [31:0] cableDly_q, userDly_q, assistSec_q, prdata_q;
    logic assistArm_q, initPend_q;
    logic [31:0] locSec_q;
    logic [29:0] locNs_q;
    logic [15:0] frac_q;
    logic [2:0] sync_q;
    logic lvl_q;
    logic [31:0] riseSec_q, fallSec_q, repRiseSec_q, repFallSec_q;
    logic [29:0] riseNs_q, fallNs_q, repRiseNs_q, repFallNs_q;
    logic newRise_q, newFall_q, markValid_q;
    logic [15:0] markCnt_q;
    logic [31:0] repInfo_q, repAcc_q, markAcc_q;
    logic [31:0] nextSec_q, phase_q, perNs_q, widNs_q, cycCnt_q, freqMeas_q;
    logic [29:0] nextNs_q, prevCNs_q;
    logic markStb_q, nextStb_q, pulse_q;

    logic pulseEn, rateFreq, widRatio, alignSec, altLock, pol, freqLock;
    logic markEn, locked, rise, fall, tos, ptick, resync, pulseStart;
    logic [2:0] srcSel;
    logic [31:0] selPer, selWid, perCalc, widCalc, corr, stepSum, nsSum;
    logic [31:0] phSum, phaseNext;
    logic [15:0] nsAdd;
    logic signed [33:0] offS, dlyS, gNsS;
    logic [31:0] gSec, mSec, cSec, nSec;
    logic [29:0] gNs, mNs, cNs, nNs;
    logic apbWr, apbRdSetup, mapped;
    logic [31:0] rdMux;
    // Brings a nanosecond sum back into 0..1 s, one wrap at most
    function automatic logic [61:0] tnorm(input logic [31:0] s,
                                          input logic signed [33:0] n);
        logic signed [33:0] full;
        full = $signed({4'h0, NS_PER_SEC});
        if (n < 0) begin
            tnorm = {s - 32'h1, 30'(n + full)};
        end else if (n >= full) begin
            tnorm = {s + 32'h1, 30'(n - full)};
        end else begin
            tnorm = {s, n[29:0]};
        end
    endfunction
    // ------------------------------
    // Control fields and mode selection
    // ------------------------------
    assign pulseEn = ctrl_q[CB_PULSE_EN];
    assign rateFreq = ctrl_q[CB_RATE_FREQ];
    assign widRatio = ctrl_q[CB_WID_RATIO];
    assign alignSec = ctrl_q[CB_ALIGN];
    assign altLock = ctrl_q[CB_ALT_LOCK];
    assign pol = ctrl_q[CB_POL];
    assign freqLock = ctrl_q[CB_FREQ_LOCK];
    assign markEn = ctrl_q[CB_MARK_EN];
    assign srcSel = ctrl_q[CB_GRID_LO +: 3];
    assign locked = altLock & timeValid;
    assign selPer = locked ? lockPer_q : unlkPer_q;
    assign selWid = locked ? lockWid_q : unlkWid_q;
    // Wide dividers; result registered to keep them off later paths
    always_comb begin
        if (!rateFreq) begin
            perCalc = 32'(64'(selPer) * NS_PER_US);
        end else if (selPer == 32'h0) begin
            perCalc = 32'h0;
        end else begin
            perCalc = 32'(64'(NS_PER_SEC) / 64'(selPer));
        end
        if (widRatio) begin
            widCalc = 32'((64'(perNs_q) * 64'(selWid)) / PCT_FULL);
        end else begin
            widCalc = 32'(64'(selWid) * NS_PER_US);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            perNs_q <= 32'h0;
            widNs_q <= 32'h0;
        end else begin
            perNs_q <= perCalc;
            widNs_q <= widCalc;
        end
    end
    // ------------------------------
    // Local time base
    // ------------------------------
    assign corr = (freqLock && gnssFreqValid) ?
                  {{16{freqCorr[15]}}, freqCorr} : 32'h0;
    assign stepSum = {16'h0, frac_q} + STEP_BASE + corr;
    assign nsAdd = stepSum[31:16];
    assign nsSum = 32'(locNs_q) + 32'(nsAdd);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            locSec_q <= 32'h0;
            locNs_q <= 30'h0;
            frac_q <= 16'h0;
            initPend_q <= 1'b1;
        end else begin
            frac_q <= stepSum[15:0];
            initPend_q <= 1'b0;
            if (initPend_q && rtcValid) begin
                locSec_q <= rtcSec;
                locNs_q <= rtcNs;
            end else if (rise && assistArm_q) begin
                locSec_q <= assistSec_q;
                locNs_q <= 30'h0;
            end else if (nsSum >= 32'(NS_PER_SEC)) begin
                locSec_q <= locSec_q + 32'h1;
                locNs_q <= 30'(nsSum - 32'(NS_PER_SEC));
            end else begin
                locNs_q <= nsSum[29:0];
            end
        end
    end
    // ------------------------------
    // Grid time and delay compensation
    // ------------------------------
    assign offsetSel = srcSel;
    assign offS = (srcSel == SRC_LOCAL) ? 34'sh0 :
                  34'($signed(gridOffsetNs));
    assign dlyS = 34'($signed(cableDly_q)) + 34'($signed(userDly_q));
    assign gNsS = $signed({4'h0, locNs_q}) + offS;
    assign {gSec, gNs} = tnorm(locSec_q, gNsS);
    assign {mSec, mNs} = tnorm(gSec, $signed({4'h0, gNs}) - dlyS);
    assign {cSec, cNs} = tnorm(gSec, $signed({4'h0, gNs}) + dlyS);
    assign {nSec, nNs} = tnorm(cSec, $signed({4'h0, cNs}) +
                               $signed({2'h0, perNs_q}));
    // ------------------------------
    // Pulse generator
    // ------------------------------
    // Resync only at second wraps, so periods above 1 s cannot align
    assign tos = cNs < prevCNs_q;
    assign resync = alignSec & timeValid & tos;
    assign phSum = phase_q + 32'(nsAdd);
    assign ptick = phSum >= perNs_q;
    assign pulseStart = resync | ptick;
    always_comb begin
        if (resync) begin
            phaseNext = 32'(cNs);
        end else if (ptick) begin
            phaseNext = phSum - perNs_q;
        end else begin
            phaseNext = phSum;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_q <= 32'h0;
            prevCNs_q <= 30'h0;
            pulse_q <= 1'b0;
        end else begin
            phase_q <= phaseNext;
            prevCNs_q <= cNs;
            if (pulseEn && perNs_q != 32'h0 && phaseNext < widNs_q) begin
                pulse_q <= pol;
            end else begin
                pulse_q <= ~pol;
            end
        end
    end
    assign periodic_pulse_output = pulse_q;
    // Next pulse report, one per pulse start
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nextSec_q <= 32'h0;
            nextNs_q <= 30'h0;
            nextStb_q <= 1'b0;
        end else begin
            nextStb_q <= pulseStart & pulseEn;
            if (pulseStart && pulseEn) begin
                nextSec_q <= nSec;
                nextNs_q <= nNs;
            end
        end
    end
    assign nextPulseStrobe = nextStb_q;
    // ------------------------------
    // External input synchroniser and edge detection
    // ------------------------------
    assign rise = (sync_q[1] == sync_q[2]) & sync_q[2] & ~lvl_q;
    assign fall = (sync_q[1] == sync_q[2]) & ~sync_q[2] & lvl_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync_q <= 3'h0;
            lvl_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], external_event_input};
            if (sync_q[1] == sync_q[2]) begin
                lvl_q <= sync_q[2];
            end
        end
    end

    // Rising-edge spacing in cycles, for frequency assistance
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cycCnt_q <= 32'h0;
            freqMeas_q <= 32'h0;
        end else if (rise) begin
            freqMeas_q <= cycCnt_q + 32'h1;
            cycCnt_q <= 32'h0;
        end else if (cycCnt_q != 32'hffff_ffff) begin
            cycCnt_q <= cycCnt_q + 32'h1;
        end
    end
    // ------------------------------
    // Time marks and epoch report
    // ------------------------------
    // Latest edges overwrite earlier ones within an epoch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            riseSec_q <= 32'h0;
            riseNs_q <= 30'h0;
            fallSec_q <= 32'h0;
            fallNs_q <= 30'h0;
            markCnt_q <= 16'h0;
            markValid_q <= 1'b0;
            markAcc_q <= 32'h0;
        end else begin
            if (rise) begin
                riseSec_q <= mSec;
                riseNs_q <= mNs;
            end
            if (fall) begin
                fallSec_q <= mSec;
                fallNs_q <= mNs;
            end
            if (rise || fall) begin
                markCnt_q <= markCnt_q + 16'h1;
                markValid_q <= timeValid;
                markAcc_q <= timeAccNs;
            end
        end
    end

    // An edge in the epoch cycle survives into the next epoch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            newRise_q <= 1'b0;
            newFall_q <= 1'b0;
        end else begin
            newRise_q <= rise | (newRise_q & ~epochTick);
            newFall_q <= fall | (newFall_q & ~epochTick);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            repRiseSec_q <= 32'h0;
            repRiseNs_q <= 30'h0;
            repFallSec_q <= 32'h0;
            repFallNs_q <= 30'h0;
            repInfo_q <= 32'h0;
            repAcc_q <= 32'h0;
            markStb_q <= 1'b0;
        end else begin
            markStb_q <= 1'b0;
            if (epochTick && markEn && (newRise_q || newFall_q)) begin
                markStb_q <= 1'b1;
                repRiseSec_q <= riseSec_q;
                repRiseNs_q <= riseNs_q;
                repFallSec_q <= fallSec_q;
                repFallNs_q <= fallNs_q;
                repAcc_q <= markAcc_q;
                repInfo_q <= {markCnt_q, 10'h0, markValid_q, srcSel,
                              newFall_q, newRise_q};
            end
        end
    end
    assign markReportStrobe = markStb_q;
    // ------------------------------
    // APB register file
    // ------------------------------
    assign apbWr = psel & penable & pwrite;
    assign apbRdSetup = psel & ~penable & ~pwrite;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            unlkPer_q <= PER_RST;
            unlkWid_q <= WID_RST;
            lockPer_q <= PER_RST;
            lockWid_q <= WID_RST;
            cableDly_q <= 32'h0;
            userDly_q <= 32'h0;
            assistSec_q <= 32'h0;
        end else if (apbWr) begin
            unique case (paddr)
                REG_CTRL: ctrl_q <= pwdata & CTRL_WMASK;
                REG_UNLK_PER: unlkPer_q <= pwdata;
                REG_UNLK_WID: unlkWid_q <= pwdata;
                REG_LOCK_PER: lockPer_q <= pwdata;
                REG_LOCK_WID: lockWid_q <= pwdata;
                REG_CABLE_DLY: cableDly_q <= pwdata;
                REG_USER_DLY: userDly_q <= pwdata;
                REG_ASSIST_SEC: assistSec_q <= pwdata;
                default: ;
            endcase
        end
    end

    // Arming by software wins over the clear at a coinciding edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            assistArm_q <= 1'b0;
        end else if (apbWr && paddr == REG_CTRL && pwdata[CB_ASSIST_ARM]) begin
            assistArm_q <= 1'b1;
        end else if (rise) begin
            assistArm_q <= 1'b0;
        end
    end

    always_comb begin
        mapped = 1'b1;
        rdMux = 32'h0;
        unique case (paddr)
            REG_CTRL: rdMux = ctrl_q | (32'(assistArm_q) << CB_ASSIST_ARM);
            REG_UNLK_PER: rdMux = unlkPer_q;
            REG_UNLK_WID: rdMux = unlkWid_q;
            REG_LOCK_PER: rdMux = lockPer_q;
            REG_LOCK_WID: rdMux = lockWid_q;
            REG_CABLE_DLY: rdMux = cableDly_q;
            REG_USER_DLY: rdMux = userDly_q;
            REG_ASSIST_SEC: rdMux = assistSec_q;
            REG_STATUS: rdMux = {26'h0, gnssFreqValid, assistArm_q, lvl_q,
                                 pulse_q, locked, timeValid};
            REG_MARK_INFO: rdMux = repInfo_q;
            REG_RISE_SEC: rdMux = repRiseSec_q;
            REG_RISE_NS: rdMux = 32'(repRiseNs_q);
            REG_FALL_SEC: rdMux = repFallSec_q;
            REG_FALL_NS: rdMux = 32'(repFallNs_q);
            REG_MARK_ACC: rdMux = repAcc_q;
            REG_NEXT_SEC: rdMux = nextSec_q;
            REG_NEXT_NS: rdMux = 32'(nextNs_q);
            REG_FREQ_MEAS: rdMux = freqMeas_q;
            REG_LOCAL_SEC: rdMux = locSec_q;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata_q <= 32'h0;
        end else if (apbRdSetup) begin
            prdata_q <= rdMux;
        end
    end
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = psel & penable & ~mapped;
endmodule // gtpm_time_pulse_mark

`default_nettype wire

/* testbench/gtpm_time_pulse_mark_properties.sv */
// Port-level properties of the time pulse and mark block
`default_nettype none
module gtpm_time_pulse_mark_properties
    import gtpm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // Pins, epoch and strobes
    input wire logic periodic_pulse_output,
    input wire logic epochTick,
    input wire logic [2:0] offsetSel,
    input wire logic markReportStrobe,
    input wire logic nextPulseStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic [31:0] shadowCtrl_q;
    logic [1:0] age_q;
    logic ctrlWr;
    logic busErr;
    assign ctrlWr = psel && penable && pwrite && paddr == REG_CTRL;
    assign busErr = psel && penable && paddr > REG_LOCAL_SEC;
    // Age saturates so the idle level is judged once the write has settled
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shadowCtrl_q <= CTRL_RST;
            age_q <= 2'h0;
        end else if (ctrlWr) begin
            shadowCtrl_q <= pwdata & CTRL_WMASK;
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    a_epoch_report: assert property (
        markReportStrobe |-> $past(epochTick)) else $error("report no epoch");
    a_report_enabled: assert property (
        markReportStrobe |-> $past(shadowCtrl_q[CB_MARK_EN]))
        else $error("report while disabled");
    a_report_single: assert property (
        markReportStrobe |=> !markReportStrobe) else $error("long report");
    a_idle_level: assert property (
        age_q == 2'h3 && !shadowCtrl_q[CB_PULSE_EN] |->
        periodic_pulse_output == !shadowCtrl_q[CB_POL])
        else $error("pulse while disabled");
    a_grid_follow: assert property (
        ctrlWr |=> offsetSel == $past(pwdata[10:8])) else $error("grid sel");
    a_err_unmapped: assert property (
        busErr |-> pslverr) else $error("no error on unmapped");
    a_err_mapped: assert property (
        psel && penable && !busErr && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped");
    a_next_single: assert property (
        nextPulseStrobe |=> !nextPulseStrobe) else $error("long next strobe");
    a_reset_quiet: assert property (@(posedge sys_clk) disable iff (1'b0)
        rst |=> !markReportStrobe && !nextPulseStrobe)
        else $error("strobe in reset");
    cover property (markReportStrobe);
    cover property (nextPulseStrobe);
    cover property (busErr && pslverr);
endmodule // gtpm_time_pulse_mark_properties

bind gtpm_time_pulse_mark gtpm_time_pulse_mark_properties u_props (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
    .periodic_pulse_output, .epochTick, .offsetSel, .markReportStrobe,
    .nextPulseStrobe
);
`default_nettype wire

/* testbench/gtpm_host_model.sv */
// Host model that drives the external event input
`default_nettype none
module gtpm_host_model (
    // Clock
    input wire logic sys_clk,
    // Pin
    output logic evIn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial evIn = 1'b0;
    // Phases under five cycles would break the 50 ns minimum
    task automatic pulse(input int hi, input int lo);
        repeat (lo < 5 ? 5 : lo) @(posedge sys_clk);
        evIn <= 1'b1;
        repeat (hi < 5 ? 5 : hi) @(posedge sys_clk);
        evIn <= 1'b0;
    endtask
    // Half periods of 100 cycles or more keep it at or under 500 kHz
    task automatic square(input int half, input int n);
        repeat (n) pulse(half < 100 ? 100 : half, half < 100 ? 100 : half);
    endtask
endmodule // gtpm_host_model
`default_nettype wire

/* testbench/gtpm_time_pulse_mark_tb.sv */
// Self-checking bench for the time pulse and mark block
`default_nettype none
module gtpm_time_pulse_mark_tb
    import gtpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic epochTick = 1'b0;
    logic timeValid = 1'b0;
    logic gnssFreqValid = 1'b0;
    logic [31:0] timeAccNs = 32'h0;
    logic pready, pslverr, evIn, pulseOut, markStb, nextStb;
    logic [31:0] prdata, rd, r;
    logic [2:0] offsetSel;
    logic [64:0] expQ[$];
    logic [64:0] e;
    logic [7:0] rstA[6] = '{REG_CTRL, REG_UNLK_PER, REG_UNLK_WID,
        REG_LOCK_PER, REG_LOCK_WID, 8'h4c};
    logic [31:0] rstV[6] = '{CTRL_RST, PER_RST, WID_RST, PER_RST, WID_RST,
        32'h0};
    int failures = 0;
    int cmp_count = 0;
    int strobes = 0;
    int w, w2, s;
    always #5 sys_clk = ~sys_clk;
    gtpm_time_pulse_mark u_gtpm_time_pulse_mark (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .external_event_input(evIn),
        .periodic_pulse_output(pulseOut), .epochTick(epochTick),
        .timeValid(timeValid), .gnssFreqValid(gnssFreqValid),
        .freqCorr(16'h0), .timeAccNs(timeAccNs), .offsetSel(offsetSel),
        .gridOffsetNs(32'h0), .rtcValid(1'b1), .rtcSec(32'h3),
        .rtcNs(30'h0), .markReportStrobe(markStb), .nextPulseStrobe(nextStb)
    );
    gtpm_host_model u_gtpm_host_model (.sys_clk(sys_clk), .evIn(evIn));
    // --------------------------------------------------------------
    // Bench tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic dir, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= dir;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] v, input logic er);
        expQ.push_back({er, m, v});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic epoch();
        repeat (6) @(posedge sys_clk);
        epochTick <= 1'b1;
        @(posedge sys_clk);
        epochTick <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    // Counts on the falling edge so registered levels have settled
    task automatic meas(input logic lvl, output int act, output int per);
        act = 0;
        while (pulseOut !== !lvl) @(negedge sys_clk);
        while (pulseOut !== lvl) @(negedge sys_clk);
        while (pulseOut === lvl) begin
            act++;
            @(negedge sys_clk);
        end
        per = act;
        while (pulseOut !== lvl) begin
            per++;
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
    endtask
    task automatic pt(input logic [31:0] c, input int hi, input int per);
        int a;
        int p;
        wr(REG_CTRL, c);
        repeat (3) meas(c[CB_POL], a, p);
        chk(32'(a), 32'(hi));
        chk(32'(p), 32'(per));
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (markStb === 1'b1) strobes++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = expQ.pop_front();
            chk(prdata & e[63:32], e[31:0]);
            chk({31'h0, pslverr}, {31'h0, e[64]});
        end
    end
    initial begin
        #1000000;
        failures++;
        $display("[ERR] %0t: timeout", $time);
        tally_and_finish();
    end
    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        void'($urandom(44892));
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        foreach (rstA[i]) rdx(rstA[i], 32'hffffffff, rstV[i], i == 5);
        rdx(REG_LOCAL_SEC, 32'hffffffff, 32'h3, 1'b0);
        wr(REG_STATUS, 32'hffffffff);
        wr(8'h80, 32'h0);
        for (int g = 0; g < 5; g++) begin
            wr(REG_CTRL, 32'(g) << 8);
            rdx(REG_CTRL, 32'h700, 32'(g) << 8, 1'b0);
        end
        $display("test registers done");
        wr(REG_CTRL, 32'h1500);
        w = 5 + $urandom % 30;
        w2 = 5 + $urandom % 30;
        timeAccNs <= $urandom;
        u_gtpm_host_model.pulse(w, 10);
        s = strobes;
        epoch();
        chk(32'(strobes), 32'(s + 1));
        rdx(REG_MARK_INFO, 32'hffff001f, 32'h00020017, 1'b0);
        rdx(REG_MARK_ACC, 32'hffffffff, timeAccNs, 1'b0);
        rdx(REG_RISE_NS, 32'h0, 32'h0, 1'b0);
        r = rd;
        rdx(REG_FALL_NS, 32'hffffffff, r + 32'(w * 10), 1'b0);
        u_gtpm_host_model.pulse(w, 10);
        u_gtpm_host_model.pulse(w2, 10);
        epoch();
        rdx(REG_MARK_INFO, 32'hffff001f, 32'h00060017, 1'b0);
        rdx(REG_RISE_NS, 32'h0, 32'h0, 1'b0);
        r = rd;
        rdx(REG_FALL_NS, 32'hffffffff, r + 32'(w2 * 10), 1'b0);
        s = strobes;
        epoch();
        wr(REG_CTRL, 32'h500);
        u_gtpm_host_model.pulse(w, 10);
        epoch();
        chk(32'(strobes), 32'(s));
        wr(REG_ASSIST_SEC, 32'h7);
        wr(REG_CTRL, 32'h10500);
        u_gtpm_host_model.pulse(5, 5);
        repeat (8) @(posedge sys_clk);
        rdx(REG_LOCAL_SEC, 32'hffffffff, 32'h7, 1'b0);
        u_gtpm_host_model.square(100, 4);
        rdx(REG_FREQ_MEAS, 32'hffffffff, 32'hc8, 1'b0);
        $display("test marks done");
        wr(REG_UNLK_PER, 32'h4);
        wr(REG_UNLK_WID, 32'h1);
        wr(REG_LOCK_PER, 32'h2);
        wr(REG_LOCK_WID, 32'h1);
        pt(32'h521, 100, 400);
        pt(32'h501, 100, 400);
        wr(REG_UNLK_WID, 32'h19);
        pt(32'h525, 100, 400);
        wr(REG_UNLK_WID, 32'h1);
        wr(REG_UNLK_PER, 32'h3d090);
        pt(32'h523, 100, 400);
        wr(REG_UNLK_PER, 32'h4);
        timeValid <= 1'b1;
        gnssFreqValid <= 1'b1;
        pt(32'h571, 100, 200);
        timeValid <= 1'b0;
        pt(32'h571, 100, 400);
        wr(REG_CTRL, 32'h520);
        repeat (20) @(posedge sys_clk);
        $display("test pulses done");
        tally_and_finish();
    end
endmodule // gtpm_time_pulse_mark_tb
`default_nettype wire
